// ---- logic/ptk_pkg.sv ----
// Package: register map, field layout and bus carrier for the periodic tick down-counter
package ptk_pkg;
	localparam int unsigned CNT_W = 24;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned ADDR_W = 32;

	// Register byte addresses
	localparam logic [ADDR_W-1:0] ADDR_CTRL = 32'he000e010;
	localparam logic [ADDR_W-1:0] ADDR_RELOAD = 32'he000e014;
	localparam logic [ADDR_W-1:0] ADDR_CURRENT = 32'he000e018;
	localparam logic [ADDR_W-1:0] ADDR_CALIB = 32'he000e01c;

	// Control and status fields
	localparam int unsigned CTRL_ENABLE_BIT = 0;
	localparam int unsigned CTRL_IRQ_EN_BIT = 1;
	localparam int unsigned CTRL_SRC_BIT = 2;
	localparam int unsigned CTRL_FLAG_BIT = 16;
	localparam int unsigned CTRL_W = 3;

	// Calibration fields
	localparam int unsigned CALIB_INEXACT_BIT = 30;
	localparam int unsigned CALIB_NO_REFERENCE_FLAG_BIT = 31;

	// Reset values and counter constants
	localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h0;
	localparam logic [CNT_W-1:0] RELOAD_RESET = 24'h000000;
	localparam logic [CNT_W-1:0] CURRENT_RESET = 24'h000000;
	localparam logic [DATA_W-1:0] CALIB_RESET = 32'h00000004;
	localparam logic [DATA_W-1:0] READ_ZERO = 32'h00000000;
	localparam logic [CNT_W-1:0] CNT_ONE = 24'h000001;
	localparam logic [CNT_W-1:0] CNT_ZERO = 24'h000000;

	// One register access per cycle from the processor side
	typedef struct packed {
		logic wr_en;
		logic rd_en;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} ptk_bus_req_t;
endpackage

// ---- logic/ptk_timer.sv ----
// Periodic 24-bit tick down-counter with its register file
`timescale 1ns/100ps

module ptk_timer
(
	input wire logic mclk, // System clock, 100 MHz
	input wire logic rst_n, // Synchronous reset, active low
	input wire ptk_pkg::ptk_bus_req_t bus_req, // Register access request
	input wire logic [ptk_pkg::DATA_W-1:0] sysconfig_calib_value, // Calibration word from system configuration
	output logic [ptk_pkg::DATA_W-1:0] rd_data, // Read data, one cycle after the read
	output logic rd_valid, // Read data valid pulse
	output logic tick_irq // Tick interrupt pulse
);
	import ptk_pkg::*;

	logic [CTRL_W-1:0] ctrl_q;
	logic [CNT_W-1:0] reload_q;
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;
	logic [DATA_W-1:0] calib_q;
	logic flag_q;
	logic half_q;
	logic irq_q;
	logic [DATA_W-1:0] rd_data_q;
	logic rd_valid_q;
	logic tick;
	logic zero_evt;
	logic wr_ctrl;
	logic wr_reload;
	logic wr_current;
	logic rd_ctrl;
	logic rd_current;
	logic enable;
	logic irq_en;
	logic src_full;

	function automatic logic hit(input ptk_bus_req_t r, input logic [ADDR_W-1:0] a);
		hit = (r.addr == a);
	endfunction

	function automatic logic [DATA_W-1:0] widen(input logic [CNT_W-1:0] v);
		widen = {{(DATA_W-CNT_W){1'b0}}, v};
	endfunction

	function automatic logic [DATA_W-1:0] ctrl_word(input logic [CTRL_W-1:0] c, input logic f);
		ctrl_word = READ_ZERO;
		ctrl_word[CTRL_W-1:0] = c;
		ctrl_word[CTRL_FLAG_BIT] = f;
	endfunction

	assign enable = ctrl_q[CTRL_ENABLE_BIT];
	assign irq_en = ctrl_q[CTRL_IRQ_EN_BIT];
	assign src_full = ctrl_q[CTRL_SRC_BIT];
	assign wr_ctrl = bus_req.wr_en && hit(bus_req, ADDR_CTRL);
	assign wr_reload = bus_req.wr_en && hit(bus_req, ADDR_RELOAD);
	assign wr_current = bus_req.wr_en && hit(bus_req, ADDR_CURRENT);
	assign rd_ctrl = bus_req.rd_en && hit(bus_req, ADDR_CTRL);
	assign rd_current = bus_req.rd_en && hit(bus_req, ADDR_CURRENT);

	assign tick = src_full ? 1'b1 : half_q;

	// Event taken at the 1 to 0 step, so a zero reload never fires
	// zero event
	assign zero_evt = enable && tick && (cnt_q == CNT_ONE);

	// Divider runs free, so the first slow tick after enable may come a cycle late
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			half_q <= 1'b0;
		else
			half_q <= ~half_q;
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			ctrl_q <= CTRL_RESET;
		else if (wr_ctrl)
			ctrl_q <= bus_req.wdata[CTRL_W-1:0];
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			reload_q <= RELOAD_RESET;
		else if (wr_reload)
			reload_q <= bus_req.wdata[CNT_W-1:0];
	end

	always_comb
	begin
		cnt_d = cnt_q;
		if (wr_current)
			cnt_d = CNT_ZERO;
		else if (enable && tick)
			cnt_d = (cnt_q == CNT_ZERO) ? reload_q : cnt_q - CNT_ONE;
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			cnt_q <= CURRENT_RESET;
		else
			cnt_q <= cnt_d;
	end

	// sticky flag, set wins over clear
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			flag_q <= 1'b0;
		else if (zero_evt)
			flag_q <= 1'b1;
		else if (rd_ctrl || wr_current)
			flag_q <= 1'b0;
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			irq_q <= 1'b0;
		else
			irq_q <= zero_evt && irq_en;
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			calib_q <= CALIB_RESET;
		else
			calib_q <= sysconfig_calib_value;
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			rd_data_q <= READ_ZERO;
			rd_valid_q <= 1'b0;
		end
		else
		begin
			rd_valid_q <= bus_req.rd_en;
			if (!bus_req.rd_en)
				rd_data_q <= READ_ZERO;
			else if (rd_ctrl)
				rd_data_q <= ctrl_word(ctrl_q, flag_q);
			else if (hit(bus_req, ADDR_RELOAD))
				rd_data_q <= widen(reload_q);
			else if (rd_current)
				rd_data_q <= widen(cnt_q);
			else if (hit(bus_req, ADDR_CALIB))
				rd_data_q <= calib_q;
			else
				rd_data_q <= READ_ZERO;
		end
	end

	assign rd_data = rd_data_q;
	assign rd_valid = rd_valid_q;
	assign tick_irq = irq_q;

	property p_count_down;
		@(posedge mclk) disable iff (!rst_n)
		(enable && tick && !wr_current && cnt_q > CNT_ONE) |=> (cnt_q == $past(cnt_q) - CNT_ONE);
	endproperty
	a_count_down: assert property (p_count_down) else $error("counter did not decrement on tick");

	property p_hold;
		@(posedge mclk) disable iff (!rst_n)
		(!enable && !wr_current) |=> $stable(cnt_q);
	endproperty
	a_hold: assert property (p_hold) else $error("counter moved while disabled");

	property p_irq;
		@(posedge mclk) disable iff (!rst_n)
		tick_irq == $past(zero_evt && irq_en);
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt does not match zero event");

	property p_half_rate;
		@(posedge mclk) disable iff (!rst_n)
		(!src_full && tick) |=> (src_full || !tick);
	endproperty
	a_half_rate: assert property (p_half_rate) else $error("half-rate tick on consecutive cycles");

	property p_flag_read;
		@(posedge mclk) disable iff (!rst_n)
		(rd_ctrl && !zero_evt) ##1 rd_valid |-> !flag_q && rd_data[CTRL_FLAG_BIT] == $past(flag_q);
	endproperty
	a_flag_read: assert property (p_flag_read) else $error("flag read or clear wrong");

	property p_reload;
		@(posedge mclk) disable iff (!rst_n)
		(enable && tick && !wr_current && cnt_q == CNT_ZERO) |=> (cnt_q == $past(reload_q));
	endproperty
	a_reload: assert property (p_reload) else $error("reload not taken at zero");

	property p_read_current;
		@(posedge mclk) disable iff (!rst_n)
		rd_current |=> (rd_data == {{(DATA_W-CNT_W){1'b0}}, $past(cnt_q)});
	endproperty
	a_read_current: assert property (p_read_current) else $error("current value read mismatch");

	property p_clear_current;
		@(posedge mclk) disable iff (!rst_n)
		(wr_current && !zero_evt) |=> (cnt_q == CNT_ZERO && !flag_q);
	endproperty
	a_clear_current: assert property (p_clear_current) else $error("current write did not clear");

	property p_start_reload;
		@(posedge mclk) disable iff (!rst_n)
		(cnt_q == CNT_ZERO && enable && src_full && !wr_current) |=> (cnt_q == $past(reload_q)) [*1];
	endproperty
	a_start_reload: assert property (p_start_reload) else $error("start not from reload value");

	property p_calib;
		@(posedge mclk) disable iff (!rst_n)
		$rose(rst_n) |-> calib_q == CALIB_RESET ##1 calib_q == $past(sysconfig_calib_value);
	endproperty
	a_calib: assert property (p_calib) else $error("calibration word wrong");

	property p_flag_set;
		@(posedge mclk) disable iff (!rst_n)
		zero_evt |=> flag_q && cnt_q == CNT_ZERO;
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("zero event did not set flag");

	property p_irq_cause;
		@(posedge mclk) disable iff (!rst_n)
		tick_irq |-> (cnt_q == CNT_ZERO && $past(irq_en) && $past(enable) && $past(cnt_q) == CNT_ONE);
	endproperty
	a_irq_cause: assert property (p_irq_cause) else $error("interrupt without a zero transition");

	property p_irq_masked;
		@(posedge mclk) disable iff (!rst_n)
		!irq_en |=> !tick_irq;
	endproperty
	a_irq_masked: assert property (p_irq_masked) else $error("interrupt raised while masked");

	property p_read_idle;
		@(posedge mclk) disable iff (!rst_n)
		!bus_req.rd_en |=> (!rd_valid && rd_data == READ_ZERO);
	endproperty
	a_read_idle: assert property (p_read_idle) else $error("read data not idle without a read");

	property p_read_valid;
		@(posedge mclk) disable iff (!rst_n)
		bus_req.rd_en |=> rd_valid;
	endproperty
	a_read_valid: assert property (p_read_valid) else $error("read answer missing");

	property p_read_ctrl;
		@(posedge mclk) disable iff (!rst_n)
		rd_ctrl |=> (rd_data[CTRL_W-1:0] == $past(ctrl_q) && rd_data[CTRL_FLAG_BIT] == $past(flag_q) && rd_data[CTRL_FLAG_BIT-1:CTRL_W] == '0 && rd_data[DATA_W-1:CTRL_FLAG_BIT+1] == '0);
	endproperty
	a_read_ctrl: assert property (p_read_ctrl) else $error("control read word wrong");

	property p_read_reload;
		@(posedge mclk) disable iff (!rst_n)
		(bus_req.rd_en && hit(bus_req, ADDR_RELOAD)) |=> (rd_data[CNT_W-1:0] == $past(reload_q) && rd_data[DATA_W-1:CNT_W] == '0);
	endproperty
	a_read_reload: assert property (p_read_reload) else $error("reload read wrong");

	property p_read_calib;
		@(posedge mclk) disable iff (!rst_n)
		(bus_req.rd_en && hit(bus_req, ADDR_CALIB)) |=> (rd_data == $past(calib_q));
	endproperty
	a_read_calib: assert property (p_read_calib) else $error("calibration read wrong");

	property p_zero_idle;
		@(posedge mclk) disable iff (!rst_n)
		(reload_q == CNT_ZERO && cnt_q == CNT_ZERO && !wr_current) |=> (cnt_q == CNT_ZERO && !tick_irq);
	endproperty
	a_zero_idle: assert property (p_zero_idle) else $error("zero reload left idle state");

	property p_flag_sticky;
		@(posedge mclk) disable iff (!rst_n)
		(flag_q && !rd_ctrl && !wr_current) |=> flag_q;
	endproperty
	a_flag_sticky: assert property (p_flag_sticky) else $error("flag lost without a clear");

	property p_flag_fall;
		@(posedge mclk) disable iff (!rst_n)
		$fell(flag_q) |-> $past(rd_ctrl || wr_current);
	endproperty
	a_flag_fall: assert property (p_flag_fall) else $error("flag cleared without read or write");
endmodule

// ---- tb/tb.sv ----
// Self-checking testbench for the periodic tick down-counter
`timescale 1ns/100ps
module tb;
	import ptk_pkg::*;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	ptk_bus_req_t bus_req = '0;
	logic [DATA_W-1:0] calib_in = 32'h00000004;
	logic [DATA_W-1:0] rd_data;
	logic rd_valid;
	logic tick_irq;
	int n_errors = 0;
	int comparisons = 0;
	int n;
	always #5 mclk = ~mclk;
	ptk_timer u_dut
	(
		.mclk(mclk),
		.rst_n(rst_n),
		.bus_req(bus_req),
		.sysconfig_calib_value(calib_in),
		.rd_data(rd_data),
		.rd_valid(rd_valid),
		.tick_irq(tick_irq)
	);
	task automatic stop_test();
		$display("Comparisons %0d, mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			n_errors++;
			$display("BAD at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One access: request held for one edge, then idle
	task automatic acc(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge mclk);
		bus_req <= '{wr_en: w, rd_en: !w, addr: a, wdata: d};
		@(posedge mclk);
		bus_req <= '0;
		#1;
	endtask
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		acc(1'b1, a, d);
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
		acc(1'b0, a, '0);
		chk({31'h0, rd_valid}, 32'h1);
		chk(rd_data, exp);
		@(posedge mclk);
		#1;
		chk({31'h0, rd_valid}, 32'h0);
		chk(rd_data, 32'h0);
	endtask
	// Counts cycles until the next interrupt pulse
	task automatic wait_irq(output int cyc);
		cyc = 0;
		do
		begin
			@(posedge mclk);
			#1;
			cyc++;
		end
		while (tick_irq !== 1'b1 && cyc < 200);
		if (tick_irq !== 1'b1)
		begin
			chk({31'h0, tick_irq}, 32'h1);
			stop_test();
		end
	endtask
	initial
	begin
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		rd(ADDR_CTRL, 32'h00000000);
		rd(ADDR_RELOAD, 32'h00000000);
		rd(ADDR_CURRENT, 32'h00000000);
		rd(ADDR_CALIB, 32'h00000004);
		rd(32'he000e020, 32'h00000000);
		$display("Test reset values done");
		wr(ADDR_RELOAD, 32'hffffffff);
		rd(ADDR_RELOAD, 32'h00ffffff);
		wr(ADDR_RELOAD, 32'h00000003);
		wr(ADDR_CURRENT, 32'h00000000);
		wr(ADDR_CTRL, 32'h00000007);
		wait_irq(n);
		wait_irq(n);
		chk(n, 32'h4);
		wr(ADDR_CTRL, 32'h00000000);
		rd(ADDR_CTRL, 32'h00010000);
		rd(ADDR_CTRL, 32'h00000000);
		$display("Test full rate period done");
		wr(ADDR_CURRENT, 32'h00000000);
		wr(ADDR_CTRL, 32'h00000003);
		wait_irq(n);
		wait_irq(n);
		chk(n, 32'h8);
		wr(ADDR_CTRL, 32'h00000000);
		$display("Test half rate period done");
		wr(ADDR_CTRL, 32'h00000005);
		repeat (20)
		begin
			@(posedge mclk);
			#1;
			chk({31'h0, tick_irq}, 32'h0);
		end
		wr(ADDR_CTRL, 32'h00000000);
		wr(ADDR_CURRENT, 32'h12345678);
		rd(ADDR_CTRL, 32'h00000000);
		rd(ADDR_CURRENT, 32'h00000000);
		$display("Test masked interrupt and clear done");
		wr(ADDR_RELOAD, 32'h00000100);
		wr(ADDR_CTRL, 32'h00000005);
		wr(ADDR_CTRL, 32'h00000000);
		repeat (10) @(posedge mclk);
		rd(ADDR_CURRENT, 32'h000000ff);
		rd(ADDR_CURRENT, 32'h000000ff);
		$display("Test start from reload and hold done");
		@(posedge mclk);
		calib_in <= 32'hc0abcdef;
		wr(ADDR_CALIB, 32'h00000000);
		rd(ADDR_CALIB, 32'hc0abcdef);
		$display("Test calibration done");
		stop_test();
	end
endmodule
